//--- rtl/scf_defs.svh
// scf_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the command-layer state machine
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SCF_OFF_CTRL 12'h000
`define SCF_OFF_STAT 12'h004
`define SCF_OFF_IRQ_STS 12'h008
`define SCF_OFF_IRQ_MSK 12'h00C
`define SCF_OFF_TFD 12'h010
`define SCF_OFF_SIG 12'h014
`define SCF_OFF_CCC 12'h018
`define SCF_OFF_CMD_ISSUE 12'h01C
`define SCF_OFF_RXBASE 12'h020
`define SCF_OFF_DEBUG 12'h024

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SCF_CTRL_FBS_EN 0
`define SCF_CTRL_CCC_EN 1
`define SCF_CTRL_DHR_EN 2
`define SCF_CTRL_GIE 3
`define SCF_CTRL_SIG_UPD 4

// ----------------------------------------
// irq status fields
// ----------------------------------------
`define SCF_IRQ_DHRS 0
`define SCF_IRQ_FATAL 1
`define SCF_IRQ_W 2

// ----------------------------------------
// taskfile status bits
// ----------------------------------------
`define SCF_STS_ERR 0
`define SCF_STS_DRQ 3
`define SCF_STS_BSY 7

// ----------------------------------------
// constants
// ----------------------------------------
`define SCF_NO_SLOT 6'h20
`define SCF_PACKET_CMD_AREA_MAX 16'h0010
`define SCF_PMP_STRIDE 32'h0000_0100
`define SCF_REGFIS_OFFSET_OFF 32'h0000_0040
`define SCF_DESC_FETCH 4'h1
`define SCF_DATA_FETCH 4'h1

`endif

//--- rtl/scf_pkg.sv
// scf_pkg.sv: types of the command-layer state machine
// assumes: scf_defs.svh is on the include path
package scf_pkg;
  `include "scf_defs.svh"

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [4:0] {
    scf_st_idle = 5'h00,
    scf_st_desc_prefetch = 5'h01,
    scf_st_write_data_prefetch = 5'h03,
    scf_st_switching_idle = 5'h02,
    scf_st_packet_cmd_send = 5'h06,
    scf_st_a = 5'h07,
    scf_st_fatal = 5'h05,
    scf_st_b = 5'h04,
    scf_st_cmd_clear = 5'h0C,
    scf_st_completion_count = 5'h0D,
    scf_st_set_interrupt = 5'h0F,
    scf_st_set_global_status = 5'h0E,
    scf_st_raise_interrupt = 5'h0A,
    scf_st_sig_check = 5'h0B,
    scf_st_sig_load = 5'h09,
    scf_st_power_aggressive = 5'h08,
    scf_st_fatal_taskfile = 5'h18
  } scf_state_t;

  // received register fis fields
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic irq_bit;
    logic [31:0] sig;
  } scf_regfis_t;

  // memory write request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } scf_memreq_t;

  // whole module state
  typedef struct packed {
    scf_state_t st;
    logic [31:0] rdata;
    logic pready;
    logic [4:0] ctrl;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic [15:0] tfd;
    logic [31:0] sig;
    logic [31:0] ccc;
    logic [31:0] cmd_issue;
    logic [31:0] rx_base;
    logic [5:0] issued_slot;
    logic [15:0] busy_track;
    logic [15:0] data_req_track;
    logic [15:0] pending_packet_flag;
    logic global_port_pending;
    logic port_irq;
    logic [3:0] mux_port_field;
    logic [15:0] pkt_len;
    logic pkt_start;
    logic [3:0] fetch_cnt;
    logic desc_fetch;
    logic data_fetch;
    scf_memreq_t fis_copy;
    logic [31:0] xfer_byte_count;
    logic hdr_wr;
    scf_regfis_t fis;
  } scf_reg_t;
endpackage

//--- rtl/scf_cmd_fsm.sv
// scf_cmd_fsm.sv: per-port command-layer state machine with its apb registers
// assumes: single clock pclk, apb master on the register side, link and memory
// engines outside answer with one-cycle strobes from the same clock domain
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "scf_defs.svh"

module scf_cmd_fsm
  import scf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command-layer entry events
  input wire logic cfis_ok,
  input wire logic hdr_prefetch,
  input wire logic hdr_write,
  input wire logic atapi_go,
  input wire logic [3:0] hdr_mux_port,
  input wire logic [15:0] remaining_xfer_count,
  input wire logic [3:0] current_mux_port,
  input wire logic [4:0] slot,
  input wire logic queued_dev_status,
  input wire logic [31:0] xfer_bytes,
  // link results
  input wire logic tx_done,
  input wire logic tx_err,
  // received register fis
  input wire logic rx_regfis,
  input wire scf_regfis_t rx_fis,
  // memory side
  input wire logic mem_done,
  output scf_memreq_t fis_copy,
  output logic desc_fetch,
  output logic data_fetch,
  output logic pkt_start,
  output logic [15:0] pkt_len,
  output logic [3:0] mux_port_field,
  output logic [31:0] xfer_byte_count,
  output logic hdr_wr,
  output logic [15:0] pending_packet_flag,
  output logic [4:0] state,
  output logic port_irq,
  output logic irq
);

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  scf_reg_t r; // current state
  scf_reg_t next_r; // next state
  logic wr_acc; // apb write access phase
  logic rd_acc; // apb read setup phase
  logic mapped; // address decodes
  logic [31:0] rmux; // read mux
  logic [7:0] fsts; // fis status byte

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign fsts = r.fis.status;

  // ----------------------------------------
  // address decode and read mux
  // ----------------------------------------
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `SCF_OFF_CTRL: rmux = {27'h0, r.ctrl};
      `SCF_OFF_STAT: rmux = {24'h0, r.global_port_pending, r.port_irq, 1'b0, r.st};
      `SCF_OFF_IRQ_STS: rmux = {30'h0, r.irq_sts};
      `SCF_OFF_IRQ_MSK: rmux = {30'h0, r.irq_msk};
      `SCF_OFF_TFD: rmux = {16'h0, r.tfd};
      `SCF_OFF_SIG: rmux = r.sig;
      `SCF_OFF_CCC: rmux = r.ccc;
      `SCF_OFF_CMD_ISSUE: rmux = r.cmd_issue;
      `SCF_OFF_RXBASE: rmux = r.rx_base;
      `SCF_OFF_DEBUG: rmux = {10'h0, r.issued_slot, r.busy_track};
      default: begin
        rmux = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_r = r;
    // single-cycle strobes fall back each cycle
    next_r.pkt_start = 1'b0;
    next_r.desc_fetch = 1'b0;
    next_r.data_fetch = 1'b0;
    next_r.hdr_wr = 1'b0;
    // apb: setup cycle prepares, access cycle answers
    next_r.pready = psel & ~penable;
    if (rd_acc) begin
      next_r.rdata = rmux;
    end
    // software writes
    if (wr_acc && mapped) begin
      unique case (paddr)
        `SCF_OFF_CTRL: next_r.ctrl = pwdata[4:0];
        `SCF_OFF_IRQ_MSK: next_r.irq_msk = pwdata[1:0];
        `SCF_OFF_IRQ_STS: begin
          next_r.irq_sts = r.irq_sts & ~pwdata[1:0];
          // software clearing the regfis bit drops the port interrupt
          if (pwdata[`SCF_IRQ_DHRS]) begin
            next_r.port_irq = 1'b0;
            next_r.global_port_pending = 1'b0;
          end
        end
        `SCF_OFF_CMD_ISSUE: next_r.cmd_issue = r.cmd_issue | pwdata;
        `SCF_OFF_RXBASE: next_r.rx_base = pwdata;
        default: next_r.ctrl = r.ctrl;
      endcase
    end
    // state machine
    unique case (r.st)
      scf_st_idle, scf_st_switching_idle, scf_st_power_aggressive, scf_st_a: begin
        if (rx_regfis) begin
          next_r.fis = rx_fis;
          // copy fis to memory first
          next_r.fis_copy.valid = 1'b1;
          next_r.fis_copy.addr = r.rx_base + ({28'h0, current_mux_port} * `SCF_PMP_STRIDE)
            + `SCF_REGFIS_OFFSET_OFF;
          next_r.st = scf_st_b;
        end else if (atapi_go) begin
          next_r.pkt_len = (remaining_xfer_count < `SCF_PACKET_CMD_AREA_MAX) ? remaining_xfer_count
            : `SCF_PACKET_CMD_AREA_MAX;
          next_r.mux_port_field = hdr_mux_port;
          next_r.pending_packet_flag[current_mux_port] = 1'b0;
          next_r.pkt_start = 1'b1;
          next_r.st = scf_st_packet_cmd_send;
        end else if (cfis_ok && hdr_prefetch) begin
          next_r.fetch_cnt = `SCF_DESC_FETCH;
          next_r.st = scf_st_desc_prefetch;
        end
      end
      scf_st_desc_prefetch: begin
        // one descriptor strobe per cycle until the chosen count is fetched
        next_r.desc_fetch = 1'b1;
        next_r.fetch_cnt = r.fetch_cnt - 4'h1;
        if (r.fetch_cnt > 4'h1) begin
          next_r.st = scf_st_desc_prefetch;
        end else if (hdr_write) begin
          next_r.fetch_cnt = `SCF_DATA_FETCH;
          next_r.st = scf_st_write_data_prefetch;
        end else if (r.ctrl[`SCF_CTRL_FBS_EN]) begin
          next_r.st = scf_st_switching_idle;
        end else begin
          next_r.st = scf_st_idle;
        end
      end
      scf_st_write_data_prefetch: begin
        // one write data strobe per cycle until the chosen amount is fetched
        next_r.data_fetch = 1'b1;
        next_r.fetch_cnt = r.fetch_cnt - 4'h1;
        if (r.fetch_cnt > 4'h1) begin
          next_r.st = scf_st_write_data_prefetch;
        end else begin
          next_r.st = r.ctrl[`SCF_CTRL_FBS_EN] ? scf_st_switching_idle : scf_st_idle;
        end
      end
      scf_st_packet_cmd_send: begin
        if (tx_err) begin
          next_r.st = scf_st_fatal;
        end else if (tx_done) begin
          next_r.st = scf_st_a;
        end
      end
      scf_st_b: begin
        if (mem_done) begin
          next_r.fis_copy.valid = 1'b0;
          next_r.tfd = {r.fis.error, fsts};
          next_r.busy_track[current_mux_port] = fsts[`SCF_STS_BSY];
          next_r.data_req_track[current_mux_port] = fsts[`SCF_STS_DRQ];
          if (fsts[`SCF_STS_ERR]) begin
            next_r.st = scf_st_fatal_taskfile;
          end else if (!fsts[`SCF_STS_BSY] && !fsts[`SCF_STS_DRQ]) begin
            next_r.st = scf_st_cmd_clear;
          end else begin
            next_r.st = scf_st_sig_check;
          end
        end
      end
      scf_st_cmd_clear: begin
        next_r.xfer_byte_count = xfer_bytes;
        next_r.hdr_wr = 1'b1;
        if (r.issued_slot != `SCF_NO_SLOT) begin
          next_r.cmd_issue[r.issued_slot[4:0]] = 1'b0;
        end
        next_r.issued_slot = `SCF_NO_SLOT;
        if (r.ctrl[`SCF_CTRL_CCC_EN] && !queued_dev_status) begin
          next_r.st = scf_st_completion_count;
        end else if (r.fis.irq_bit) begin
          next_r.st = scf_st_set_interrupt;
        end else begin
          next_r.st = scf_st_sig_check;
        end
      end
      scf_st_completion_count: begin
        next_r.ccc = r.ccc + 32'h1;
        next_r.st = r.fis.irq_bit ? scf_st_set_interrupt : scf_st_sig_check;
      end
      scf_st_set_interrupt: begin
        next_r.irq_sts[`SCF_IRQ_DHRS] = 1'b1;
        next_r.st = r.ctrl[`SCF_CTRL_DHR_EN] ? scf_st_set_global_status : scf_st_sig_check;
      end
      scf_st_set_global_status: begin
        next_r.global_port_pending = 1'b1;
        next_r.st = r.ctrl[`SCF_CTRL_GIE] ? scf_st_raise_interrupt : scf_st_sig_check;
      end
      scf_st_raise_interrupt: begin
        next_r.port_irq = 1'b1;
        next_r.st = scf_st_sig_check;
      end
      scf_st_sig_check: begin
        if (r.ctrl[`SCF_CTRL_SIG_UPD] && !r.ctrl[`SCF_CTRL_FBS_EN]) begin
          next_r.st = scf_st_sig_load;
        end else begin
          next_r.st = scf_st_power_aggressive;
        end
      end
      scf_st_sig_load: begin
        next_r.sig = r.fis.sig;
        next_r.ctrl[`SCF_CTRL_SIG_UPD] = 1'b0;
        next_r.st = scf_st_power_aggressive;
      end
      scf_st_fatal, scf_st_fatal_taskfile: begin
        next_r.irq_sts[`SCF_IRQ_FATAL] = 1'b1;
        next_r.st = scf_st_idle;
      end
      default: next_r.st = scf_st_idle;
    endcase
    // track issued slot on cfis_ok, except in state scf_st_cmd_clear
    if (cfis_ok && r.st != scf_st_cmd_clear) begin
      next_r.issued_slot = {1'b0, slot};
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.issued_slot <= `SCF_NO_SLOT;
      r.pending_packet_flag <= 16'hFFFF;
      r.st <= scf_st_idle;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = r.rdata;
  assign pready = r.pready;
  assign pslverr = ~mapped & psel & penable;
  assign fis_copy = r.fis_copy;
  assign desc_fetch = r.desc_fetch;
  assign data_fetch = r.data_fetch;
  assign pkt_start = r.pkt_start;
  assign pkt_len = r.pkt_len;
  assign mux_port_field = r.mux_port_field;
  assign xfer_byte_count = r.xfer_byte_count;
  assign hdr_wr = r.hdr_wr;
  assign pending_packet_flag = r.pending_packet_flag;
  assign state = r.st;
  assign port_irq = r.port_irq;
  assign irq = |(r.irq_sts & r.irq_msk);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_pref;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_desc_prefetch && r.fetch_cnt <= 4'h1 && hdr_write |=> r.st == scf_st_write_data_prefetch;
  endproperty
  a_pref: assert property (p_pref) else $error("prefetch branch wrong");

  property p_len;
    @(posedge pclk) disable iff (!presetn)
    pkt_start |-> pkt_len == (($past(remaining_xfer_count) < `SCF_PACKET_CMD_AREA_MAX) ? $past(remaining_xfer_count)
      : `SCF_PACKET_CMD_AREA_MAX);
  endproperty
  a_len: assert property (p_len) else $error("packet length not min of count and 16");

  property p_txerr;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_packet_cmd_send && tx_err |=> r.st == scf_st_fatal;
  endproperty
  a_txerr: assert property (p_txerr) else $error("tx error not fatal");

  property p_errb;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_b && mem_done && fsts[`SCF_STS_ERR] |=> r.st == scf_st_fatal_taskfile;
  endproperty
  a_errb: assert property (p_errb) else $error("taskfile error missed");

  property p_clr;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_cmd_clear |=> r.issued_slot == `SCF_NO_SLOT || $past(cfis_ok);
  endproperty
  a_clr: assert property (p_clr) else $error("slot not cleared");

  property p_ccc;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_completion_count |=> r.ccc == $past(r.ccc) + 32'h1;
  endproperty
  a_ccc: assert property (p_ccc) else $error("count not incremented");

  property p_dhrs;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_set_interrupt |=> r.irq_sts[`SCF_IRQ_DHRS];
  endproperty
  a_dhrs: assert property (p_dhrs) else $error("status bit not set");

  property p_sig;
    @(posedge pclk) disable iff (!presetn)
    r.st == scf_st_sig_check && r.ctrl[`SCF_CTRL_FBS_EN] |=> r.st == scf_st_power_aggressive;
  endproperty
  a_sig: assert property (p_sig) else $error("signature while switching");

  c_pkt: cover property (@(posedge pclk) r.st == scf_st_packet_cmd_send ##1 r.st == scf_st_a);
  c_irq: cover property (@(posedge pclk) $rose(port_irq));
  c_sig: cover property (@(posedge pclk) r.st == scf_st_sig_load);
endmodule

//--- dv/scf_link_model.sv
// scf_link_model.sv: far side of the block, the link engine and the memory engine
// assumes: same pclk domain; answers the registered strobes of scf_cmd_fsm
`timescale 1ns/100ps
module scf_link_model
  import scf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire scf_memreq_t fis_copy,
  input wire logic pkt_start,
  input wire logic slow,
  input wire logic fail,
  output logic mem_done,
  output logic tx_done,
  output logic tx_err
);
  logic [1:0] mcnt; // memory wait cycles so far
  logic [2:0] tcnt; // link frame cycles so far
  logic tbusy; // a data frame is on the wire
  // ----------------------------------------
  // memory copy answer and link frame result
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mcnt, tcnt, tbusy, mem_done, tx_done, tx_err} <= '0;
    end else begin
      mem_done <= 1'b0;
      tx_done <= 1'b0;
      tx_err <= 1'b0;
      // prompt or slow, one done per request
      if (fis_copy.valid && !mem_done) begin
        mcnt <= mcnt + 2'd1;
        if (!slow || mcnt == 2'd3) begin
          mem_done <= 1'b1;
          mcnt <= 2'd0;
        end
      end
      if (pkt_start) begin
        tbusy <= 1'b1;
      end
      // frame ends with R_OK or with an error
      if (tbusy) begin
        tcnt <= tcnt + 3'd1;
        if (tcnt == 3'd4) begin
          tbusy <= 1'b0;
          tcnt <= 3'd0;
          tx_done <= !fail;
          tx_err <= fail;
        end
      end
    end
  end
endmodule

//--- dv/test_scf_cmd_fsm.sv
// test_scf_cmd_fsm.sv: self-checking bench, apb master and event driver
// assumes: scf_pkg compiled first, scf_defs.svh on the include path
`timescale 1ns/100ps
`include "scf_defs.svh"
module test_scf_cmd_fsm;
  import scf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, xfer_byte_count, rdat, cp_addr;
  logic pready, pslverr, serr, desc_fetch, data_fetch, pkt_start, hdr_wr, port_irq, irq;
  logic cfis_ok = 0, hdr_prefetch = 1, hdr_write = 0, atapi_go = 0, qds = 0, rx_regfis = 0, slow = 0, fail = 0;
  logic [3:0] hdr_mux_port = 4'h5, cur_port = 4'h0, mux_port_field;
  logic [15:0] rem_cnt = 16'h000C, pkt_len, pending_packet_flag;
  logic [4:0] slot = 5'h07, state;
  logic mem_done, tx_done, tx_err;
  scf_regfis_t rx_fis = '0;
  scf_memreq_t fis_copy;
  int err_count = 0, checked = 0, desc_n = 0, data_n = 0, hdr_n = 0;
  always #2.5 pclk = ~pclk;
  scf_cmd_fsm i_scf_cmd_fsm (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfis_ok(cfis_ok),
    .hdr_prefetch(hdr_prefetch), .hdr_write(hdr_write), .atapi_go(atapi_go), .hdr_mux_port(hdr_mux_port),
    .remaining_xfer_count(rem_cnt), .current_mux_port(cur_port), .slot(slot), .queued_dev_status(qds),
    .xfer_bytes(32'h0000_0200), .tx_done(tx_done), .tx_err(tx_err), .rx_regfis(rx_regfis), .rx_fis(rx_fis),
    .mem_done(mem_done), .fis_copy(fis_copy), .desc_fetch(desc_fetch), .data_fetch(data_fetch),
    .pkt_start(pkt_start), .pkt_len(pkt_len), .mux_port_field(mux_port_field), .xfer_byte_count(xfer_byte_count),
    .hdr_wr(hdr_wr), .pending_packet_flag(pending_packet_flag), .state(state), .port_irq(port_irq), .irq(irq));
  scf_link_model i_scf_link_model (.pclk(pclk), .presetn(presetn), .fis_copy(fis_copy), .pkt_start(pkt_start),
    .slow(slow), .fail(fail), .mem_done(mem_done), .tx_done(tx_done), .tx_err(tx_err));
  // ----------------------------------------
  // pulse counters and copy address capture
  // ----------------------------------------
  // counted mid-cycle so a pulse is in before the edge that ends it
  always @(negedge pclk) begin
    if (desc_fetch === 1'b1) desc_n++;
    if (data_fetch === 1'b1) data_n++;
    if (hdr_wr === 1'b1) hdr_n++;
    if (fis_copy.valid === 1'b1) cp_addr = fis_copy.addr;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // apb transfer: setup, access until pready, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task wait_st(input scf_state_t t);
    for (int i = 0; i < 100 && state !== t; i++) @(posedge pclk);
    chk("state", t, state);
  endtask
  // one received register fis, status and error given
  task regfis(input logic [7:0] s, input logic [7:0] e, input logic ib, input logic [31:0] g);
    rx_fis <= '{s, e, ib, g};
    rx_regfis <= 1'b1;
    @(posedge pclk);
    rx_regfis <= 1'b0;
    // let the entry state show before looking for the end state
    @(posedge pclk);
    wait_st(s[`SCF_STS_ERR] ? scf_st_idle : scf_st_power_aggressive);
  endtask
  task report_and_stop;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    report_and_stop;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("pending", 32'h0000_FFFF, pending_packet_flag);
    rd("stat", `SCF_OFF_STAT, 32'h0);
    rd("unmapped", 12'h030, 32'h0);
    chk("pslverr", 32'h1, serr);
    wr(`SCF_OFF_RXBASE, 32'h0000_1000);
    wr(`SCF_OFF_IRQ_MSK, 32'h3);
    // all four prefetch exits: {switching, write bit}
    for (int k = 0; k < 4; k++) begin
      wr(`SCF_OFF_CTRL, {31'h0, !k[0]});
      hdr_write <= (k == 0 || k == 3);
      cfis_ok <= 1'b1;
      @(posedge pclk);
      cfis_ok <= 1'b0;
      wait_st(k[0] ? scf_st_idle : scf_st_switching_idle);
      chk("desc", (k + 1) * `SCF_DESC_FETCH, desc_n);
      chk("data", (k == 0 ? 1 : (k == 3 ? 2 : 1)) * `SCF_DATA_FETCH, data_n);
    end
    // packet command: short count ok, long count with link error
    for (int k = 0; k < 2; k++) begin
      fail <= k[0];
      rem_cnt <= k[0] ? 16'h0011 : 16'h000C;
      cur_port <= k[0] ? 4'h9 : 4'h2;
      atapi_go <= 1'b1;
      @(posedge pclk);
      atapi_go <= 1'b0;
      wait_st(k[0] ? scf_st_idle : scf_st_a);
      chk("len", k[0] ? 32'h10 : 32'hC, pkt_len);
      chk("pmp", 32'h5, mux_port_field);
      chk("pending", k[0] ? 32'hFDFB : 32'hFFFB, pending_packet_flag);
    end
    rd("fatal", `SCF_OFF_IRQ_STS, 32'h2);
    wr(`SCF_OFF_IRQ_STS, 32'h2);
    // full completion with coalescing, interrupt chain and signature
    slow <= 1'b1;
    cur_port <= 4'h3;
    wr(`SCF_OFF_CMD_ISSUE, 32'h80);
    wr(`SCF_OFF_CTRL, 32'h1E);
    regfis(8'h50, 8'h00, 1'b1, 32'hA5C3_0F1E);
    chk("addr", 32'h0000_1340, cp_addr);
    rd("tfd", `SCF_OFF_TFD, 32'h0050);
    chk("bytes", 32'h200, xfer_byte_count);
    chk("hdr_wr", 32'h1, hdr_n);
    rd("ci", `SCF_OFF_CMD_ISSUE, 32'h0);
    rd("ccc", `SCF_OFF_CCC, 32'h1);
    rd("sts", `SCF_OFF_IRQ_STS, 32'h1);
    chk("port_irq", 32'h1, port_irq);
    chk("irq", 32'h1, irq);
    rd("sig", `SCF_OFF_SIG, 32'hA5C3_0F1E);
    rd("ctrl", `SCF_OFF_CTRL, 32'h0E);
    wr(`SCF_OFF_IRQ_STS, 32'h1);
    chk("port_irq", 32'h0, port_irq);
    chk("irq", 32'h0, irq);
    // busy device with switching on: no clear, no signature
    wr(`SCF_OFF_CTRL, 32'h11);
    regfis(8'h80, 8'h00, 1'b1, 32'h1234_5678);
    rd("tfd", `SCF_OFF_TFD, 32'h0080);
    rd("sts", `SCF_OFF_IRQ_STS, 32'h0);
    rd("sig", `SCF_OFF_SIG, 32'hA5C3_0F1E);
    // queued status set, global enable off
    slow <= 1'b0;
    qds <= 1'b1;
    wr(`SCF_OFF_CMD_ISSUE, 32'h80);
    wr(`SCF_OFF_CTRL, 32'h06);
    regfis(8'h40, 8'h00, 1'b1, 32'h0);
    rd("ccc", `SCF_OFF_CCC, 32'h1);
    rd("sig", `SCF_OFF_SIG, 32'hA5C3_0F1E);
    rd("ci", `SCF_OFF_CMD_ISSUE, 32'h80);
    rd("stat", `SCF_OFF_STAT, {24'h0, 1'b1, 1'b0, 1'b0, scf_st_power_aggressive});
    chk("irq", 32'h1, irq);
    wr(`SCF_OFF_IRQ_MSK, 32'h0);
    chk("irq", 32'h0, irq);
    wr(`SCF_OFF_IRQ_STS, 32'h3);
    // error bit set: fatal taskfile then idle
    regfis(8'h41, 8'h05, 1'b0, 32'h0);
    rd("tfd", `SCF_OFF_TFD, 32'h0541);
    rd("fatal", `SCF_OFF_IRQ_STS, 32'h2);
    report_and_stop;
  end
endmodule
